// >>> verilog/adc_input_reference_select.v
`timescale 1ns/1ps
`include "input_select_defines.vh"
module adc_input_reference_select (
  input wire clk, // system clock
  input wire rst, // synchronous reset
  input wire [7:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes
  output reg [31:0] avs_readdata, // read data
  output reg avs_waitrequest, // stall
  output reg avs_response_err_r, // unmapped read flag
  input wire [9:0] conv_raw, // raw code from converter
  input wire sram2_retention, // SRAM2 in retention, from pin
  input wire [7:0] sram2_rdata, // SRAM2 read data
  output reg [7:0] sram2_rdata_out_r, // gated SRAM2 read data
  output reg [5:0] active_channel_r, // channel applied to analog
  output reg [1:0] active_reference_r, // reference applied
  output reg internal_ref_on_r, // internal reference powered
  output reg [1:0] pga_gain_r, // amplifier gain code
  output reg diff_mode_r, // differential coding
  output reg conv_busy_r, // conversion in progress
  output reg [15:0] result_r // aligned result
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [7:0] sel_r;
  reg chan_high_buf_r;
  reg chan_high_r;
  reg enable_r;
  reg ref_locked_r;
  reg done_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] cnt_r;
  reg [5:0] pending_chan_r;
  reg [9:0] raw_r;
  reg ret_s1_r;
  reg ret_s2_r;
  reg ack_r;
  wire [15:0] shaped;
  wire hit_sel;
  wire hit_ctl;
  wire hit_sts;
  wire hit_res;
  wire start_req;

  // gain per channel code
  function [1:0] chan_gain;
    input [5:0] ch;
    begin
      if (ch == `CH_RET_DROP || ch == `CH_RET_SHIFT) begin
        chan_gain = `GAIN_HALF;
      end else if (ch == `CH_TEMP) begin
        chan_gain = `GAIN_10;
      end else if (ch[5:3] == 3'h1) begin
        chan_gain = ch[1] ? `GAIN_200 : `GAIN_10;
      end else begin
        chan_gain = `GAIN_1;
      end
    end
  endfunction

  // differential channel test
  function chan_diff;
    input [5:0] ch;
    begin
      chan_diff = (ch == `CH_TEMP) || (ch == `CH_RET_DROP) || (ch == `CH_RET_SHIFT) ||
        (ch[5:3] == 3'h1) || (ch[5:3] == 3'h2) || (ch[5:2] == 4'h6) ||
        (ch[5:1] == 5'h0E);
    end
  endfunction

  // channels whose code cannot be negative
  function chan_nonneg;
    input [5:0] ch;
    begin
      chan_nonneg = (ch == `CH_TEMP) || (ch == `CH_RET_DROP) || (ch == `CH_RET_SHIFT);
    end
  endfunction

  assign hit_sel = (avs_address == `OFS_INPUT_SELECT);
  assign hit_ctl = (avs_address == `OFS_CONTROL);
  assign hit_sts = (avs_address == `OFS_STATUS);
  assign hit_res = (avs_address == `OFS_RESULT);
  assign start_req = avs_write && !ack_r && hit_ctl && avs_byteenable[0] &&
    avs_writedata[`CTL_START] && enable_r;

  // pin input synchroniser
  always @(posedge clk) begin
    if (rst) begin
      ret_s1_r <= 1'b0;
      ret_s2_r <= 1'b0;
    end else begin
      ret_s1_r <= sram2_retention;
      ret_s2_r <= ret_s1_r;
    end
  end

  // one wait state, then ack
  always @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // register writes
  always @(posedge clk) begin
    if (rst) begin
      sel_r <= `SEL_RESET;
      chan_high_buf_r <= 1'b0;
      chan_high_r <= 1'b0;
      enable_r <= 1'b0;
    end else if (avs_write && !ack_r && avs_byteenable[0]) begin
      if (hit_sel) begin
        sel_r <= avs_writedata[7:0];
        chan_high_r <= chan_high_buf_r;
      end
      if (hit_ctl) begin
        enable_r <= avs_writedata[`CTL_ENABLE];
        chan_high_buf_r <= avs_writedata[`CTL_CHAN_HIGH];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ref_locked_r <= 1'b0;
      active_reference_r <= `REF_PIN;
      internal_ref_on_r <= 1'b0;
    end else begin
      if (!enable_r) begin
        ref_locked_r <= 1'b0;
      end else if (start_req) begin
        ref_locked_r <= 1'b1;
      end
      if (!ref_locked_r) begin
        active_reference_r <= sel_r[`SEL_REF_HI:`SEL_REF_LO];
        internal_ref_on_r <= enable_r && sel_r[`SEL_REF_HI];
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (!enable_r) begin
          state_nxt = ST_IDLE;
        end else if (cnt_r == 8'h01) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      conv_busy_r <= 1'b0;
      raw_r <= 10'h000;
      active_channel_r <= 6'h00;
      pending_chan_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      conv_busy_r <= (state_nxt == ST_CONV);
      pending_chan_r <= {chan_high_r, sel_r[`SEL_CHAN_HI:`SEL_CHAN_LO]};
      if (state_r == ST_IDLE && start_req) begin
        cnt_r <= `CONV_CYCLES;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      if (state_r == ST_DONE) begin
        raw_r <= conv_raw;
      end
      if (state_r != ST_CONV) begin
        active_channel_r <= pending_chan_r;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      done_r <= 1'b1;
    end else if (avs_write && !ack_r && hit_sts && avs_byteenable[0] && avs_writedata[0]) begin
      done_r <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pga_gain_r <= `GAIN_1;
      diff_mode_r <= 1'b0;
    end else begin
      pga_gain_r <= chan_gain(active_channel_r);
      diff_mode_r <= chan_diff(active_channel_r);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sram2_rdata_out_r <= 8'h00;
    end else if (ret_s2_r) begin
      sram2_rdata_out_r <= 8'h00;
    end else begin
      sram2_rdata_out_r <= sram2_rdata;
    end
  end

  result_shaper u_shaper (
    .clk(clk),
    .rst(rst),
    .raw(raw_r),
    .diff(diff_mode_r),
    .nonneg(chan_nonneg(active_channel_r)),
    .left_align(sel_r[`SEL_ALIGN]),
    .shaped_r(shaped)
  );

  always @(posedge clk) begin
    if (rst) begin
      result_r <= 16'h0000;
    end else begin
      result_r <= shaped;
    end
  end

  // read mux
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
      avs_response_err_r <= 1'b0;
    end else if (avs_read && !ack_r) begin
      avs_response_err_r <= !(hit_sel || hit_ctl || hit_sts || hit_res);
      if (hit_sel) begin
        avs_readdata <= {24'h000000, sel_r};
      end else if (hit_ctl) begin
        avs_readdata <= {29'h0000000, chan_high_buf_r, 1'b0, enable_r};
      end else if (hit_sts) begin
        avs_readdata <= {26'h000000, chan_high_r, ret_s2_r, ref_locked_r, conv_busy_r, 1'b0,
          done_r};
      end else if (hit_res) begin
        avs_readdata <= {16'h0000, shaped};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end
endmodule // adc_input_reference_select

// >>> verilog/input_select_defines.vh
`ifndef INPUT_SELECT_DEFINES_VH
`define INPUT_SELECT_DEFINES_VH

// register word offsets (byte addresses)
`define OFS_INPUT_SELECT 8'h7C
`define OFS_CONTROL 8'h80
`define OFS_STATUS 8'h84
`define OFS_RESULT 8'h88

// converter_input_select fields
`define SEL_REF_HI 7
`define SEL_REF_LO 6
`define SEL_ALIGN 5
`define SEL_CHAN_HI 4
`define SEL_CHAN_LO 0
`define SEL_RESET 8'h00

// control register fields
`define CTL_ENABLE 0
`define CTL_START 1
`define CTL_CHAN_HIGH 2
`define CTL_RESET 3'h0

// reference select codes
`define REF_PIN 2'h0
`define REF_SUPPLY 2'h1
`define REF_INT_1V5 2'h2
`define REF_INT_1V6 2'h3

// special channel codes {high, low}
`define CH_TEMP 6'h29
`define CH_OFFSET 6'h08
`define CH_RET_DROP 6'h34
`define CH_RET_SHIFT 6'h3D

// gain codes
`define GAIN_1 2'h0
`define GAIN_10 2'h1
`define GAIN_200 2'h2
`define GAIN_HALF 2'h3

// conversion length in clocks
`define CONV_CYCLES 8'h0D

`endif

// >>> verilog/result_shaper.v
`timescale 1ns/1ps
module result_shaper (
  input wire clk, // system clock
  input wire rst, // synchronous reset
  input wire [9:0] raw, // raw converter code
  input wire diff, // differential coding in use
  input wire nonneg, // channel yields non-negative codes
  input wire left_align, // live alignment control
  output reg [15:0] shaped_r // aligned result
);
  reg [9:0] code;

  always @* begin
    code = raw;
    if (diff && nonneg && raw[9]) begin
      code = 10'h000;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      shaped_r <= 16'h0000;
    end else if (left_align) begin
      shaped_r <= {code, 6'h00};
    end else begin
      shaped_r <= {6'h00, code};
    end
  end
endmodule // result_shaper

// >>> tb/adc_sel_checker.sv
`timescale 1ns/1ps
`include "input_select_defines.vh"
module adc_sel_checker (
  input wire clk, // clock
  input wire rst, // reset
  input wire avs_read, // read req
  input wire avs_write, // write req
  input wire avs_waitrequest, // stall
  input wire sram2_retention, // retention pin
  input wire [7:0] sram2_rdata_out_r, // gated data
  input wire [5:0] active_channel_r, // channel
  input wire [1:0] active_reference_r, // reference
  input wire internal_ref_on_r, // int ref power
  input wire [1:0] pga_gain_r, // gain
  input wire diff_mode_r, // differential
  input wire conv_busy_r // busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_temp_gain: assert property (active_channel_r == `CH_TEMP |=>
    pga_gain_r == `GAIN_10 && diff_mode_r) else $error("temperature path wrong");
  a_offset_gain: assert property (active_channel_r == `CH_OFFSET |=>
    pga_gain_r == `GAIN_10 && diff_mode_r) else $error("offset path wrong");
  a_probe_gain: assert property ((active_channel_r == `CH_RET_DROP ||
    active_channel_r == `CH_RET_SHIFT) |=> pga_gain_r == `GAIN_HALF && diff_mode_r)
    else $error("probe path wrong");
  a_sram_zero: assert property (sram2_retention [*5] |-> sram2_rdata_out_r == 8'h00)
    else $error("block data not zero in retention");
  a_chan_hold: assert property (conv_busy_r && $past(conv_busy_r) |-> $stable(active_channel_r))
    else $error("channel changed mid conversion");
  a_ref_hold: assert property (conv_busy_r && $past(conv_busy_r) |-> $stable(active_reference_r))
    else $error("reference changed mid conversion");
  a_ref_pin_off: assert property (active_reference_r == `REF_PIN |-> !internal_ref_on_r)
    else $error("internal reference on with pin source");
  c_conv: cover property (conv_busy_r ##1 !conv_busy_r);
  c_temp: cover property (active_channel_r == `CH_TEMP);
  c_ret: cover property (sram2_retention [*5]);
endmodule // adc_sel_checker
bind adc_input_reference_select adc_sel_checker u_chk (.clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .sram2_retention, .sram2_rdata_out_r, .active_channel_r,
  .active_reference_r, .internal_ref_on_r, .pga_gain_r, .diff_mode_r, .conv_busy_r);

// >>> tb/analog_far_side.sv
`timescale 1ns/1ps
module analog_far_side (
  input wire clk, // clock
  input wire [9:0] level, // settled code
  input wire ret_req, // enter retention
  output reg [9:0] conv_raw, // raw code
  output reg sram2_retention, // retention pin
  output reg [7:0] sram2_rdata // block data
);
  initial begin
    conv_raw = 10'h000;
    sram2_retention = 1'b0;
    sram2_rdata = 8'h5A;
  end
  always @(posedge clk) begin
    // code ready at once, no pace settings to keep
    conv_raw <= level;
    sram2_retention <= ret_req;
    // live data changes every cycle
    sram2_rdata <= sram2_rdata + 8'h01;
  end
endmodule // analog_far_side

// >>> tb/tb_adc_input_reference_select.sv
`timescale 1ns/1ps
`include "input_select_defines.vh"
module tb_adc_input_reference_select;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg ret = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [31:0] q;
  reg [9:0] lvl = 10'h000;
  integer errors = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, avs_response_err_r, sram2_retention, internal_ref_on_r;
  wire diff_mode_r, conv_busy_r;
  wire [9:0] conv_raw;
  wire [7:0] sram2_rdata, sram2_rdata_out_r;
  wire [5:0] active_channel_r;
  wire [1:0] active_reference_r, pga_gain_r;
  wire [15:0] result_r;
  always #5 clk = ~clk;
  adc_input_reference_select DUT (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err_r(avs_response_err_r),
    .conv_raw(conv_raw), .sram2_retention(sram2_retention), .sram2_rdata(sram2_rdata),
    .sram2_rdata_out_r(sram2_rdata_out_r), .active_channel_r(active_channel_r),
    .active_reference_r(active_reference_r), .internal_ref_on_r(internal_ref_on_r),
    .pga_gain_r(pga_gain_r), .diff_mode_r(diff_mode_r), .conv_busy_r(conv_busy_r),
    .result_r(result_r));
  analog_far_side far (.clk(clk), .level(lvl), .ret_req(ret), .conv_raw(conv_raw),
    .sram2_retention(sram2_retention), .sram2_rdata(sram2_rdata));
  task conclude;
    begin
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    begin
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h0, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge clk);
      end
      q = avs_readdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // start, reselect mid-run, wait done, read result
  task conv(input [7:0] c, input [7:0] s, input [5:0] e);
    begin
      bus(1, `OFS_CONTROL, c | 8'h02);
      bus(1, `OFS_INPUT_SELECT, s);
      repeat (3) @(posedge clk);
      chk(active_channel_r, e);
      chk(conv_busy_r, 1'b1);
      q = 0;
      while (q[0] !== 1'b1) begin
        bus(0, `OFS_STATUS, 8'h00);
      end
      bus(1, `OFS_STATUS, 8'h01);
      bus(0, `OFS_RESULT, 8'h00);
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, `OFS_INPUT_SELECT, 8'h00);
    chk(q, 32'h0);
    bus(1, `OFS_INPUT_SELECT, 8'hFF);
    bus(0, `OFS_INPUT_SELECT, 8'h00);
    chk(q, 32'hFF);
    bus(1, `OFS_CONTROL, 8'h05);
    bus(0, `OFS_STATUS, 8'h00);
    chk(q[5], 1'b0);
    bus(1, `OFS_INPUT_SELECT, 8'hC9);
    bus(0, `OFS_STATUS, 8'h00);
    chk(q[5], 1'b1);
    chk(active_channel_r, `CH_TEMP);
    chk(pga_gain_r, `GAIN_10);
    chk(diff_mode_r, 1'b1);
    $display("select test done");
    lvl <= 10'h270;
    conv(8'h05, 8'hC9, `CH_TEMP);
    chk(q, 32'h0);
    lvl <= 10'h0F1;
    conv(8'h05, 8'hC9, `CH_TEMP);
    chk(q, 32'h00F1);
    bus(1, `OFS_INPUT_SELECT, 8'h49);
    chk(active_reference_r, `REF_INT_1V6);
    bus(1, `OFS_CONTROL, 8'h04);
    bus(1, `OFS_CONTROL, 8'h05);
    // reference pin left undriven in this bench
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, `OFS_INPUT_SELECT, {i[1:0], 6'h09});
      chk(active_reference_r, i[1:0]);
      chk(internal_ref_on_r, i[1]);
    end
    $display("temperature and reference test done");
    bus(1, `OFS_CONTROL, 8'h00);
    bus(1, `OFS_INPUT_SELECT, 8'h08);
    bus(1, `OFS_CONTROL, 8'h01);
    chk(active_channel_r, `CH_OFFSET);
    lvl <= 10'h270;
    conv(8'h01, 8'h08, `CH_OFFSET);
    chk(q, 32'h0270);
    bus(1, `OFS_INPUT_SELECT, 8'h28);
    bus(0, `OFS_RESULT, 8'h00);
    chk(q, 32'h9C00);
    chk(result_r, 32'h9C00);
    $display("offset test done");
    bus(1, `OFS_CONTROL, 8'h05);
    bus(1, `OFS_INPUT_SELECT, 8'hD4);
    repeat (2) @(posedge clk);
    chk(active_channel_r, `CH_RET_DROP);
    chk(pga_gain_r, `GAIN_HALF);
    chk(diff_mode_r, 1'b1);
    conv(8'h05, 8'hDD, `CH_RET_DROP);
    chk(q, 32'h0);
    chk(active_channel_r, `CH_RET_SHIFT);
    ret <= 1'b1;
    repeat (6) @(posedge clk);
    chk(sram2_rdata_out_r, 8'h00);
    ret <= 1'b0;
    bus(0, 8'hF0, 8'h00);
    chk(q, 32'h0);
    chk(avs_response_err_r, 1'b1);
    $display("probe and bus test done");
    conclude;
  end
endmodule // tb_adc_input_reference_select
